// [testbench/crc_scan_properties.sv]
// Concurrent checks on the ports of the CRC engine with memory scanner.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module crc_scan_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus
	input wire crc_scan_pkg::axi_lite_req_type axi_req,
	input wire crc_scan_pkg::axi_lite_resp_type axi_resp,
	// Memory port and triggers
	input wire crc_scan_pkg::mem_req_type mem_out,
	input wire crc_scan_pkg::mem_resp_type mem_in,
	input wire logic [crc_scan_pkg::TRIG_W-1:0] scan_trigger_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	a_one_fetch: assert property (mem_out.req && mem_in.grant |=> !mem_out.req)
		else $error("req in fetch");
	a_addr_held: assert property (mem_out.req && mem_in.grant |=>
		$stable(mem_out.addr) && $stable(mem_out.region)) else $error("addr moved");
	a_addr_step: assert property (mem_in.rvalid && !mem_out.req |=>
		mem_out.addr == $past(mem_out.addr) + 22'h1) else $error("addr step");
	a_write_answer: assert property (axi_req.awvalid && axi_resp.awready && axi_req.wvalid
		&& axi_resp.wready |-> ##[1:4] axi_resp.bvalid) else $error("no write answer");
	a_read_answer: assert property (axi_req.arvalid && axi_resp.arready
		|-> ##[1:2] axi_resp.rvalid) else $error("no read answer");
	a_write_locked: assert property (axi_resp.bvalid |-> !axi_resp.awready && !axi_resp.wready)
		else $error("write while busy");
	a_read_locked: assert property (axi_resp.rvalid |-> !axi_resp.arready)
		else $error("read while busy");
	a_resp_released: assert property (axi_resp.bvalid && axi_req.bready |=> !axi_resp.bvalid)
		else $error("bvalid stuck");

	c_fetch: cover property (mem_out.req && mem_in.grant);
	c_word: cover property (mem_in.rvalid);
	c_write: cover property (axi_resp.bvalid && axi_req.bready);
endmodule : crc_scan_properties

bind crc_with_memory_scanner crc_scan_properties u_props (.clk(clk), .sys_rst(sys_rst),
	.axi_req(axi_req), .axi_resp(axi_resp), .mem_out(mem_out), .mem_in(mem_in),
	.scan_trigger_in(scan_trigger_in));

`default_nettype wire

// [testbench/crc_with_memory_scanner_bench.sv]
// Self-checking bench for the CRC engine with memory scanner.
// Assumes the memory model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module crc_with_memory_scanner_bench;
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] lens;
		logic [15:0] poly;
		logic [15:0] seed;
		logic [15:0] data;
	} row_type;
	localparam row_type ROWS [4] = '{'{8'h10, 8'h7f, 16'h8004, 16'h0000, 16'h0055},
		'{8'h12, 8'hff, 16'h1020, 16'hffff, 16'ha5c3}, '{8'h00, 8'h07, 16'h0006, 16'h003c, 16'h0001},
		'{8'h02, 8'hb3, 16'h0002, 16'h0005, 16'h0abc}};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	crc_scan_pkg::axi_lite_req_type req = '0;
	crc_scan_pkg::axi_lite_resp_type resp;
	crc_scan_pkg::mem_req_type mem_out;
	crc_scan_pkg::mem_resp_type mem_in;
	logic [7:0] trig = 8'h00;
	logic hold = 1'b0;
	logic slow = 1'b0;
	logic [1:0] last_resp;
	logic [31:0] d;
	logic [15:0] acc;
	logic seen;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	crc_with_memory_scanner u_dut (.clk(clk), .sys_rst(sys_rst), .axi_req(req), .axi_resp(resp),
		.mem_out(mem_out), .mem_in(mem_in), .scan_trigger_in(trig));
	mem_partner u_mem (.clk(clk), .sys_rst(sys_rst), .mem_out(mem_out), .mem_in(mem_in),
		.hold(hold), .slow(slow));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
		total_checks++;
		if (seen_v !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen_v);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw = 1'b1;
		logic w = 1'b1;
		logic b = 1'b0;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!b) begin
			@(negedge clk);
			b = resp.bvalid;
			last_resp = resp.bresp;
			aw = aw && !resp.awready;
			w = w && !resp.wready;
			@(posedge clk);
			req.awvalid <= aw;
			req.wvalid <= w;
		end
		req.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ar = 1'b1;
		logic v = 1'b0;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		while (!v) begin
			@(negedge clk);
			v = resp.rvalid;
			d = resp.rdata;
			last_resp = resp.rresp;
			ar = ar && !resp.arready;
			@(posedge clk);
			req.arvalid <= ar;
		end
		req.rready <= 1'b0;
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		check($sformatf("reg %h", a), d, exp);
	endtask : rchk

	task automatic scan(input logic [31:0] lo, input logic [31:0] hi, input logic [7:0] c);
		wr(crc_scan_pkg::OFF_SCAN_START_ADDRESS, lo);
		wr(crc_scan_pkg::OFF_SCAN_END_ADDRESS, hi);
		wr(crc_scan_pkg::OFF_SCANNER_CONTROL, 32'(c));
	endtask : scan

	task automatic wait_flag(input int pos);
		do rd(crc_scan_pkg::OFF_FLAGS); while (d[pos] !== 1'b1);
		do rd(crc_scan_pkg::OFF_CRC_CONTROL); while (d[5] !== 1'b0 || d[0] !== 1'b0);
	endtask : wait_flag

	function automatic logic [15:0] crc_ref(input logic [15:0] a, input logic [15:0] data,
		input logic [7:0] lens, input logic [15:0] poly, input logic aug, input logic lsb);
		int n, dl;
		logic [15:0] mask;
		logic b, fb;
		n = lens[3:0] + 1;
		dl = lens[7:4] + 1;
		mask = 16'hffff >> (16 - n);
		for (int i = 0; i < dl + (aug ? n : 0); i++) begin
			b = (i >= dl) ? 1'b0 : data[lsb ? i : dl - 1 - i];
			fb = a[n - 1] ^ (~aug & b);
			a = ((a << 1) | {15'h0, aug & b}) & mask;
			if (fb) a = (a ^ poly ^ {15'h0, ~poly[0]}) & mask;
		end
		return a;
	endfunction : crc_ref

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			test_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(crc_scan_pkg::OFF_CRC_CONTROL, 32'h0);
		rchk(crc_scan_pkg::OFF_CRC_LENGTH_CONFIG, 32'h0);
		rchk(crc_scan_pkg::OFF_SCANNER_CONTROL, 32'h0);
		rd(8'h40);
		check("unmapped read", 32'(last_resp), 32'(crc_scan_pkg::RESP_SLVERR));
		wr(8'h40, 32'h0);
		check("unmapped write", 32'(last_resp), 32'(crc_scan_pkg::RESP_SLVERR));
		foreach (ROWS[i]) begin
			wr(crc_scan_pkg::OFF_POLYNOMIAL_TERMS, 32'(ROWS[i].poly));
			rchk(crc_scan_pkg::OFF_POLYNOMIAL_TERMS, 32'(ROWS[i].poly | 16'h1));
			wr(crc_scan_pkg::OFF_CRC_ACCUMULATOR, 32'(ROWS[i].seed));
			wr(crc_scan_pkg::OFF_CRC_LENGTH_CONFIG, 32'(ROWS[i].lens));
			wr(crc_scan_pkg::OFF_CRC_CONTROL, 32'(8'h80 | ROWS[i].mode));
			wr(crc_scan_pkg::OFF_CRC_DATA_HIGH, 32'(ROWS[i].data[15:8]));
			wr(crc_scan_pkg::OFF_CRC_DATA_LOW, 32'(ROWS[i].data[7:0]));
			rchk(crc_scan_pkg::OFF_CRC_CONTROL, 32'(8'ha1 | ROWS[i].mode));
			rchk(crc_scan_pkg::OFF_CRC_ACCUMULATOR, 32'(ROWS[i].seed));
			wr(crc_scan_pkg::OFF_CRC_CONTROL, 32'(8'hc0 | ROWS[i].mode));
			wait_flag(0);
			acc = crc_ref(ROWS[i].seed, ROWS[i].data, ROWS[i].lens, ROWS[i].poly,
				ROWS[i].mode[4], ROWS[i].mode[1]);
			rchk(crc_scan_pkg::OFF_CRC_ACCUMULATOR, 32'(acc));
			rchk(crc_scan_pkg::OFF_FLAGS, 32'h1);
			wr(crc_scan_pkg::OFF_FLAGS, 32'h3);
		end
		slow <= 1'b1;
		wr(crc_scan_pkg::OFF_POLYNOMIAL_TERMS, 32'h8004);
		wr(crc_scan_pkg::OFF_CRC_ACCUMULATOR, 32'hffff);
		wr(crc_scan_pkg::OFF_CRC_CONTROL, 32'hc0);
		scan(32'h10, 32'h13, 8'ha4);
		wait_flag(1);
		acc = 16'hffff;
		for (int i = 16; i < 20; i++) acc = crc_ref(acc, 16'(i) ^ 16'hee00, 8'hb3, 16'h8004, 0, 0);
		rchk(crc_scan_pkg::OFF_CRC_ACCUMULATOR, 32'(acc));
		check("scan address", 32'(mem_out.addr), 32'h14);
		rchk(crc_scan_pkg::OFF_SCANNER_CONTROL, 32'h84);
		rchk(crc_scan_pkg::OFF_FLAGS, 32'h3);
		wr(crc_scan_pkg::OFF_FLAGS, 32'h3);
		slow <= 1'b0;
		wr(crc_scan_pkg::OFF_SCAN_TRIGGER_SELECT, 32'h3);
		scan(32'h20, 32'h20, 8'he0);
		seen = 1'b0;
		repeat (20) begin
			@(negedge clk);
			seen = seen | mem_out.req;
		end
		check("request without trigger", 32'(seen), 32'h0);
		trig <= 8'h08;
		wait_flag(1);
		check("trigger address", 32'(mem_out.addr), 32'h21);
		wr(crc_scan_pkg::OFF_FLAGS, 32'h3);
		hold <= 1'b1;
		scan(32'h30, 32'h3f, 8'ha2);
		seen = 1'b1;
		repeat (20) begin
			@(negedge clk);
			seen = seen & mem_out.req;
		end
		check("burst request", 32'(seen), 32'h1);
		wr(crc_scan_pkg::OFF_CRC_CONTROL, 32'h40);
		rchk(crc_scan_pkg::OFF_SCANNER_CONTROL, 32'h82);
		hold <= 1'b0;
		wr(crc_scan_pkg::OFF_CRC_CONTROL, 32'hc0);
		scan(32'h40, 32'h3f, 8'ha0);
		rchk(crc_scan_pkg::OFF_SCANNER_CONTROL, 32'h80);
		test_done;
	end
endmodule : crc_with_memory_scanner_bench

`default_nettype wire

// [testbench/mem_partner.sv]
// Model of the system arbiter and the flash and EEPROM behind it.
// Assumes one outstanding fetch; hold stands for a higher-priority source.
`timescale 1ns/1ps
`default_nettype none

module mem_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Scanner memory port
	input wire crc_scan_pkg::mem_req_type mem_out,
	output crc_scan_pkg::mem_resp_type mem_in,
	// Higher-priority traffic and answer pacing
	input wire logic hold,
	input wire logic slow
);
	logic [2:0] count;
	logic [15:0] word;
	logic busy;
	logic valid;

	always_comb begin
		mem_in.grant = mem_out.req && !hold && !busy;
		mem_in.rvalid = valid;
		mem_in.rdata = valid ? word : ~word;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{busy, valid, count, word} <= '0;
		end else begin
			valid <= 1'b0;
			if (mem_in.grant) begin
				busy <= 1'b1;
				count <= slow ? 3'h3 : 3'h0;
				word <= 16'(mem_out.addr) ^ (mem_out.region ? 16'hee00 : 16'h1100);
			end else if (busy && count == 3'h0) begin
				busy <= 1'b0;
				valid <= 1'b1;
			end else if (busy) begin
				count <= count - 3'h1;
			end
		end
	end
endmodule : mem_partner

`default_nettype wire

// [verilog/crc_bit_step.sv]
// One shift of the CRC remainder by a single bit.
// Assumes the caller masks nothing; the result is already cut to the active width.
`timescale 1ns/1ps
`default_nettype none

module crc_bit_step (
	// Present remainder and settings
	input wire logic [15:0] acc,
	input wire logic [15:0] poly_terms,
	input wire logic [3:0] poly_length,
	input wire logic zero_augment,
	input wire logic bit_in,
	// Next remainder
	output logic [15:0] next_acc
);
	logic feedback;
	logic [15:0] shifted;
	logic [15:0] poly;
	logic [15:0] mask;

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_mask
			assign mask[i] = (4'(i) <= poly_length);
		end
	endgenerate

	// Augmented mode feeds data in at bit 0; direct mode adds it to feedback.
	assign feedback = acc[poly_length] ^ (~zero_augment & bit_in); // R08
	assign shifted = {acc[14:0], zero_augment & bit_in};
	assign poly = {poly_terms[15:1], 1'b1}; // R23
	assign next_acc = (shifted ^ (feedback ? poly : 16'h0000)) & mask; // R02

endmodule : crc_bit_step
`default_nettype wire

// [verilog/crc_scan_pkg.sv]
// Constants, register map and carrier types of the CRC engine with memory scanner.
// Assumes a 32-bit AXI4-Lite master and a system arbiter in front of flash and EEPROM.
package crc_scan_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int ADDR_W = 22;
	localparam int REG_ADDR_W = 8;
	localparam int TRIG_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] OFF_CRC_CONTROL = 8'h00;
	localparam logic [7:0] OFF_CRC_LENGTH_CONFIG = 8'h04;
	localparam logic [7:0] OFF_CRC_DATA_HIGH = 8'h08;
	localparam logic [7:0] OFF_CRC_DATA_LOW = 8'h0c;
	localparam logic [7:0] OFF_CRC_ACCUMULATOR = 8'h10;
	localparam logic [7:0] OFF_CRC_SHIFTER = 8'h14;
	localparam logic [7:0] OFF_POLYNOMIAL_TERMS = 8'h18;
	localparam logic [7:0] OFF_SCANNER_CONTROL = 8'h1c;
	localparam logic [7:0] OFF_SCAN_START_ADDRESS = 8'h20;
	localparam logic [7:0] OFF_SCAN_END_ADDRESS = 8'h24;
	localparam logic [7:0] OFF_SCAN_TRIGGER_SELECT = 8'h28;
	localparam logic [7:0] OFF_FLAGS = 8'h2c;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int BIT_CRC_ENABLE = 7;
	localparam int BIT_CRC_GO = 6;
	localparam int BIT_CRC_BUSY = 5;
	localparam int BIT_ZERO_AUGMENT = 4;
	localparam int BIT_SHIFT_ORDER = 1;
	localparam int BIT_FULL = 0;
	localparam int POS_DATA_LENGTH = 4;
	localparam int POS_POLY_LENGTH = 0;
	localparam int BIT_SCAN_ENABLE = 7;
	localparam int BIT_TRIGGER_ENABLE = 6;
	localparam int BIT_SCANNER_GO = 5;
	localparam int BIT_REGION = 2;
	localparam int BIT_BURST = 1;
	localparam int BIT_SCAN_BUSY = 0;
	localparam int BIT_CRC_DONE = 0;
	localparam int BIT_SCAN_DONE = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and bus answers.
	localparam logic [7:0] RST_CRC_CONTROL = 8'h00;
	localparam logic [7:0] RST_CRC_LENGTH_CONFIG = 8'h00;
	localparam logic [7:0] RST_SCANNER_CONTROL = 8'h00;
	localparam logic [15:0] RST_ACCUMULATOR = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Scanner memory cycle state.
	typedef enum logic [0:0] {
		SCAN_IDLE = 1'b0,
		SCAN_READ = 1'b1
	} scan_state_type;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef struct packed {
		logic [REG_ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [REG_ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} axi_lite_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_lite_resp_type;

	typedef struct packed {
		logic req;
		logic region;
		logic [ADDR_W-1:0] addr;
	} mem_req_type;

	typedef struct packed {
		logic grant;
		logic rvalid;
		logic [15:0] rdata;
	} mem_resp_type;

endpackage : crc_scan_pkg

// [verilog/crc_with_memory_scanner.sv]
// CRC engine with memory scanner, registers on an AXI4-Lite slave.
// Assumes an external arbiter grants memory cycles and returns the word later with rvalid.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R01: data_length plus one bits shift per word.
// R02: poly_length plus one sets the accumulator width.
// R03: writing crc_data_low starts the word; software writes crc_data_high first.
// R04: full reads 1 while the data registers hold an unshifted word.
// R05: busy reads 1 while shifting is in progress or pending.
// R06: crc_go starts the serial shifter; clearing it stops the shifter.
// R07: crc_enable turns the CRC on or off.
// R08: zero_augment_mode appends polynomial-length zeros after the data.
// R09: shift_order 1 shifts LSB first, 0 shifts MSB first.
// R10: a value written to the accumulator is the starting remainder.
// R11: while crc_go is set the scanner loads words whenever the CRC can accept one.
// R12: scanner reads upward from start address to end address, one word each.
// R13: scanning starts on scanner_go, stops when cleared or past the end address.
// R14: clearing crc_enable forces scanner_go to zero.
// R15: passing the end address sets scan_done_flag; only software clears it.
// R16: software sets crc_enable and crc_go before scanner_go.
// R17: normal mode requests memory only when the CRC can accept data.
// R18: trigger mode also needs the selected trigger before requesting; the code ignores the trigger when scanner_burst is set.
// R19: burst mode requests memory continuously while scanner_go is set; the code drops the request while a fetch is in SCAN_READ.
// R20: in trigger burst mode the system holds the trigger until the scan ends.
// R21: software takes the result once both flags set and busy and go clear.
// R22: each falling edge of busy sets crc_done_flag; only software clears it.
// R23: the top and bottom polynomial terms are always one.
// R24: memory_region_select 1 selects data EEPROM, 0 program flash.
// R25: scanner_go clears when start passes end with no cycle, or crc_go is 0.
module crc_with_memory_scanner (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus
	input wire crc_scan_pkg::axi_lite_req_type axi_req,
	output crc_scan_pkg::axi_lite_resp_type axi_resp,
	// Memory port toward the arbiter
	output crc_scan_pkg::mem_req_type mem_out,
	input wire crc_scan_pkg::mem_resp_type mem_in,
	// Trigger sources
	input wire logic [crc_scan_pkg::TRIG_W-1:0] scan_trigger_in
);

	////////////////////////////////////////////////////////////////////////////////
	// State.
	typedef struct packed {
		logic crc_enable;
		logic crc_go_a;
		logic zero_augment_mode;
		logic shift_order;
		logic full;
		logic [3:0] data_length;
		logic [3:0] poly_length;
		logic [15:0] data_word;
		logic [15:0] shifter;
		logic [4:0] bits_left;
		logic [4:0] aug_left;
		logic aug_pending;
		logic [15:0] crc_accumulator;
		logic [15:0] polynomial_terms;
		logic scan_enable;
		logic scanner_trigger_enable;
		logic scanner_go;
		logic memory_region_select;
		logic scanner_burst;
		logic [crc_scan_pkg::ADDR_W-1:0] scan_start_address;
		logic [crc_scan_pkg::ADDR_W-1:0] scan_end_address;
		logic [2:0] scan_trigger_select;
		logic crc_done_flag;
		logic scan_done_flag;
		logic busy_last;
		crc_scan_pkg::scan_state_type scan_state;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

	state_type s;
	state_type next_s;

	logic busy;
	logic run;
	logic step_active;
	logic step_bit;
	logic [15:0] stepped_acc;
	logic scan_ready;
	logic scan_in_range;
	logic trigger_now;
	logic mem_request;
	logic [31:0] read_word;
	logic read_known;
	logic [31:0] wval;
	logic write_known;

	////////////////////////////////////////////////////////////////////////////////
	// Byte lane merge of a write into an existing word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// Status and datapath helpers.
	assign busy = s.full | (s.bits_left != 5'h00) | (s.aug_left != 5'h00) | s.aug_pending; // R05
	assign run = s.crc_enable & s.crc_go_a; // R06 R07
	assign step_active = run & ((s.bits_left != 5'h00) | (s.aug_left != 5'h00));
	assign step_bit = (s.bits_left == 5'h00) ? 1'b0 :
		(s.shift_order ? s.shifter[0] : s.shifter[s.data_length]); // R09

	crc_bit_step u_step (
		.acc(s.crc_accumulator),
		.poly_terms(s.polynomial_terms),
		.poly_length(s.poly_length),
		.zero_augment(s.zero_augment_mode),
		.bit_in(step_bit),
		.next_acc(stepped_acc)
	);

	assign scan_ready = ~s.full & (s.scan_state == crc_scan_pkg::SCAN_IDLE); // R11
	assign scan_in_range = (s.scan_start_address <= s.scan_end_address);
	assign trigger_now = scan_trigger_in[s.scan_trigger_select];
	assign mem_request = s.scanner_go & scan_in_range & (s.scan_state == crc_scan_pkg::SCAN_IDLE)
		& (s.scanner_burst | (scan_ready & (~s.scanner_trigger_enable | trigger_now))); // R17 R18 R19

	////////////////////////////////////////////////////////////////////////////////
	// Register read view.
	always_comb begin
		read_word = 32'h0000_0000;
		read_known = 1'b1;
		unique case ({axi_req.araddr[7:2], 2'b00})
			crc_scan_pkg::OFF_CRC_CONTROL: begin
				read_word[crc_scan_pkg::BIT_CRC_ENABLE] = s.crc_enable;
				read_word[crc_scan_pkg::BIT_CRC_GO] = s.crc_go_a;
				read_word[crc_scan_pkg::BIT_CRC_BUSY] = busy; // R05
				read_word[crc_scan_pkg::BIT_ZERO_AUGMENT] = s.zero_augment_mode;
				read_word[crc_scan_pkg::BIT_SHIFT_ORDER] = s.shift_order;
				read_word[crc_scan_pkg::BIT_FULL] = s.full; // R04
			end
			crc_scan_pkg::OFF_CRC_LENGTH_CONFIG: begin
				read_word[7:0] = {s.data_length, s.poly_length};
			end
			crc_scan_pkg::OFF_CRC_DATA_HIGH: begin
				read_word[7:0] = s.data_word[15:8];
			end
			crc_scan_pkg::OFF_CRC_DATA_LOW: begin
				read_word[7:0] = s.data_word[7:0];
			end
			crc_scan_pkg::OFF_CRC_ACCUMULATOR: begin
				read_word[15:0] = s.crc_accumulator;
			end
			crc_scan_pkg::OFF_CRC_SHIFTER: begin
				read_word[15:0] = s.shifter;
			end
			crc_scan_pkg::OFF_POLYNOMIAL_TERMS: begin
				read_word[15:0] = {s.polynomial_terms[15:1], 1'b1}; // R23
			end
			crc_scan_pkg::OFF_SCANNER_CONTROL: begin
				read_word[crc_scan_pkg::BIT_SCAN_ENABLE] = s.scan_enable;
				read_word[crc_scan_pkg::BIT_TRIGGER_ENABLE] = s.scanner_trigger_enable;
				read_word[crc_scan_pkg::BIT_SCANNER_GO] = s.scanner_go;
				read_word[crc_scan_pkg::BIT_REGION] = s.memory_region_select;
				read_word[crc_scan_pkg::BIT_BURST] = s.scanner_burst;
				read_word[crc_scan_pkg::BIT_SCAN_BUSY] = (s.scan_state == crc_scan_pkg::SCAN_READ);
			end
			crc_scan_pkg::OFF_SCAN_START_ADDRESS: begin
				read_word[crc_scan_pkg::ADDR_W-1:0] = s.scan_start_address;
			end
			crc_scan_pkg::OFF_SCAN_END_ADDRESS: begin
				read_word[crc_scan_pkg::ADDR_W-1:0] = s.scan_end_address;
			end
			crc_scan_pkg::OFF_SCAN_TRIGGER_SELECT: begin
				read_word[2:0] = s.scan_trigger_select;
			end
			crc_scan_pkg::OFF_FLAGS: begin
				read_word[crc_scan_pkg::BIT_CRC_DONE] = s.crc_done_flag;
				read_word[crc_scan_pkg::BIT_SCAN_DONE] = s.scan_done_flag;
			end
			default: begin
				read_known = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		next_s = s;
		wval = merge(32'h0000_0000, s.wdata, s.wstrb);
		write_known = 1'b1;

		// Bus handshakes.
		if (axi_req.awvalid & ~s.aw_held & ~s.bvalid) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid & ~s.w_held & ~s.bvalid) begin
			next_s.w_held = 1'b1;
			next_s.wdata = axi_req.wdata;
			next_s.wstrb = axi_req.wstrb;
		end
		if (s.bvalid & axi_req.bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid & axi_req.rready) begin
			next_s.rvalid = 1'b0;
		end
		if (axi_req.arvalid & ~s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = read_word;
			next_s.rresp = read_known ? crc_scan_pkg::RESP_OKAY : crc_scan_pkg::RESP_SLVERR;
		end

		// Register writes; only bytes with a strobe change.
		if (s.aw_held & s.w_held & ~s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			unique case ({s.awaddr[7:2], 2'b00})
				crc_scan_pkg::OFF_CRC_CONTROL: begin
					if (s.wstrb[0]) begin
						next_s.crc_enable = wval[crc_scan_pkg::BIT_CRC_ENABLE]; // R07
						next_s.crc_go_a = wval[crc_scan_pkg::BIT_CRC_GO]; // R06
						next_s.zero_augment_mode = wval[crc_scan_pkg::BIT_ZERO_AUGMENT];
						next_s.shift_order = wval[crc_scan_pkg::BIT_SHIFT_ORDER];
					end
				end
				crc_scan_pkg::OFF_CRC_LENGTH_CONFIG: begin
					if (s.wstrb[0]) begin
						next_s.data_length = wval[crc_scan_pkg::POS_DATA_LENGTH +: 4]; // R01
						next_s.poly_length = wval[crc_scan_pkg::POS_POLY_LENGTH +: 4]; // R02
					end
				end
				crc_scan_pkg::OFF_CRC_DATA_HIGH: begin
					if (s.wstrb[0]) begin
						next_s.data_word[15:8] = wval[7:0];
					end
				end
				crc_scan_pkg::OFF_CRC_DATA_LOW: begin
					if (s.wstrb[0]) begin
						next_s.data_word[7:0] = wval[7:0];
						next_s.full = 1'b1; // R03
					end
				end
				crc_scan_pkg::OFF_CRC_ACCUMULATOR: begin
					next_s.crc_accumulator = 16'(merge({16'h0000, s.crc_accumulator}, s.wdata,
						s.wstrb)); // R10
				end
				crc_scan_pkg::OFF_POLYNOMIAL_TERMS: begin
					next_s.polynomial_terms = 16'(merge({16'h0000, s.polynomial_terms}, s.wdata,
						s.wstrb)) & 16'hfffe;
				end
				crc_scan_pkg::OFF_SCANNER_CONTROL: begin
					if (s.wstrb[0]) begin
						next_s.scan_enable = wval[crc_scan_pkg::BIT_SCAN_ENABLE];
						next_s.scanner_trigger_enable = wval[crc_scan_pkg::BIT_TRIGGER_ENABLE];
						next_s.scanner_go = wval[crc_scan_pkg::BIT_SCANNER_GO]; // R13
						next_s.memory_region_select = wval[crc_scan_pkg::BIT_REGION];
						next_s.scanner_burst = wval[crc_scan_pkg::BIT_BURST];
					end
				end
				crc_scan_pkg::OFF_SCAN_START_ADDRESS: begin
					next_s.scan_start_address = crc_scan_pkg::ADDR_W'(
						merge(32'(s.scan_start_address), s.wdata, s.wstrb));
				end
				crc_scan_pkg::OFF_SCAN_END_ADDRESS: begin
					next_s.scan_end_address = crc_scan_pkg::ADDR_W'(
						merge(32'(s.scan_end_address), s.wdata, s.wstrb));
				end
				crc_scan_pkg::OFF_SCAN_TRIGGER_SELECT: begin
					if (s.wstrb[0]) begin
						next_s.scan_trigger_select = wval[2:0];
					end
				end
				crc_scan_pkg::OFF_FLAGS: begin
					if (s.wstrb[0] & wval[crc_scan_pkg::BIT_CRC_DONE]) begin
						next_s.crc_done_flag = 1'b0; // R22
					end
					if (s.wstrb[0] & wval[crc_scan_pkg::BIT_SCAN_DONE]) begin
						next_s.scan_done_flag = 1'b0; // R15
					end
				end
				default: begin
					write_known = 1'b0;
				end
			endcase
			next_s.bresp = write_known ? crc_scan_pkg::RESP_OKAY : crc_scan_pkg::RESP_SLVERR;
		end

		// Serial shifter: one bit per clock while enabled and going.
		if (step_active) begin
			next_s.crc_accumulator = stepped_acc;
			if (s.bits_left != 5'h00) begin
				next_s.bits_left = s.bits_left - 5'h01; // R01
				next_s.shifter = s.shift_order ? {1'b0, s.shifter[15:1]} : {s.shifter[14:0], 1'b0};
			end else begin
				next_s.aug_left = s.aug_left - 5'h01; // R08
			end
		end else if (run & s.full) begin
			next_s.shifter = s.data_word;
			next_s.bits_left = {1'b0, s.data_length} + 5'h01; // R01
			next_s.full = 1'b0; // R04
			next_s.aug_pending = s.zero_augment_mode; // R08
		end else if (run & s.aug_pending) begin
			next_s.aug_left = {1'b0, s.poly_length} + 5'h01; // R08
			next_s.aug_pending = 1'b0;
		end

		// Scanner memory cycles.
		if (mem_request & mem_in.grant & scan_ready) begin
			next_s.scan_state = crc_scan_pkg::SCAN_READ; // R12
		end
		if ((s.scan_state == crc_scan_pkg::SCAN_READ) & mem_in.rvalid) begin
			next_s.scan_state = crc_scan_pkg::SCAN_IDLE;
			next_s.data_word = mem_in.rdata; // R11
			next_s.full = 1'b1;
			next_s.scan_start_address = s.scan_start_address + 1'b1; // R12
			if (s.scan_start_address == s.scan_end_address) begin
				next_s.scanner_go = 1'b0; // R13
				next_s.scan_done_flag = 1'b1; // R15
			end
		end
		if ((s.scan_state == crc_scan_pkg::SCAN_IDLE) & ~scan_in_range) begin
			next_s.scanner_go = 1'b0; // R25
		end
		if (~next_s.crc_go_a) begin
			next_s.scanner_go = 1'b0; // R25
		end
		if (~next_s.crc_enable) begin
			next_s.scanner_go = 1'b0; // R14
		end

		// Done flag on the falling edge of busy; a set wins over a clear.
		next_s.busy_last = busy;
		if (s.busy_last & ~busy) begin
			next_s.crc_done_flag = 1'b1; // R22
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.crc_enable <= crc_scan_pkg::RST_CRC_CONTROL[crc_scan_pkg::BIT_CRC_ENABLE];
			s.crc_go_a <= crc_scan_pkg::RST_CRC_CONTROL[crc_scan_pkg::BIT_CRC_GO];
			s.data_length <= crc_scan_pkg::RST_CRC_LENGTH_CONFIG[7:4];
			s.poly_length <= crc_scan_pkg::RST_CRC_LENGTH_CONFIG[3:0];
			s.scanner_go <= crc_scan_pkg::RST_SCANNER_CONTROL[crc_scan_pkg::BIT_SCANNER_GO];
			s.crc_accumulator <= crc_scan_pkg::RST_ACCUMULATOR;
			s.scan_state <= crc_scan_pkg::SCAN_IDLE;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	always_comb begin
		axi_resp.awready = ~s.aw_held & ~s.bvalid;
		axi_resp.wready = ~s.w_held & ~s.bvalid;
		axi_resp.bvalid = s.bvalid;
		axi_resp.bresp = s.bresp;
		axi_resp.arready = ~s.rvalid;
		axi_resp.rvalid = s.rvalid;
		axi_resp.rdata = s.rdata;
		axi_resp.rresp = s.rresp;
		mem_out.req = mem_request;
		mem_out.region = s.memory_region_select; // R24
		mem_out.addr = s.scan_start_address;
	end

endmodule : crc_with_memory_scanner
`default_nettype wire
